// *** rtl/fpc_ctrl.v ***
`default_nettype none
`include "fpc_consts.vh"
module fpc_ctrl #(
    parameter AW = 22,
    parameter DW = 16,
    parameter POLL_MAX = 5000
) (
    // Clock and reset
    input  wire          SYS_CLK_I,
    input  wire          SRST_I,
    // User command port
    input  wire          CMD_VALID_I,
    input  wire [3:0]    CMD_OP_I,
    input  wire [AW-1:0] CMD_ADDR_I,
    input  wire [DW-1:0] CMD_DATA_I,
    output reg           CMD_READY_O,
    output reg           CMD_DONE_O,
    output reg           CMD_ERR_O,
    output reg  [DW-1:0] CMD_RDATA_O,
    // Flash pins
    input  wire [DW-1:0] DQ_I,
    output wire [DW-1:0] DQ_O,
    output wire          DQ_OE_N_O,
    output wire [AW-1:0] A_O,
    output wire          CE_N_O,
    output wire          WE_N_O,
    output wire          OE_N_O
);
    // Operations
    localparam OP_ID_READ   = 4'h0; // addr: 0 maker, 1 device, 5fe irrev, else block status
    localparam OP_SECID_RD  = 4'h1;
    localparam OP_SECID_PRG = 4'h2;
    localparam OP_PSR_RD    = 4'h3;
    localparam OP_PSR_PRG   = 4'h4;
    localparam OP_VPB_SET   = 4'h5; // data 0 protect, 1 unprotect
    localparam OP_VPB_RD    = 4'h6;
    localparam OP_NONVOLATILE_PROTECT_BIT_PRG  = 4'h7;
    localparam OP_NONVOLATILE_PROTECT_BIT_ERS  = 4'h8;
    localparam OP_NONVOLATILE_PROTECT_BIT_RD   = 4'h9;
    localparam OP_BYP_PROG  = 4'ha;
    localparam OP_BYP_ERASE = 4'hb; // data carries erase code
    localparam OP_ARRAY_RD  = 4'hc;
    // States
    localparam ST_IDLE = 3'h0;
    localparam ST_SEQ  = 3'h1;
    localparam ST_WAIT = 3'h2;
    localparam ST_POLL = 3'h3;
    localparam ST_DONE = 3'h4;

    reg  [2:0]    state;
    reg  [3:0]    op;
    reg  [AW-1:0] addr;
    reg  [DW-1:0] data;
    reg  [3:0]    step;
    reg  [3:0]    nsteps;
    reg  [15:0]   poll_cnt;
    reg           poll_first;
    reg  [DW-1:0] poll_last;
    reg           err;
    reg           bc_start;
    reg           bc_wr;
    reg  [AW-1:0] bc_addr;
    reg  [DW-1:0] bc_data;
    wire          bc_done;
    wire [DW-1:0] bc_rdata;
    reg           sq_wr;
    reg  [AW-1:0] sq_addr;
    reg  [DW-1:0] sq_data;

    function [AW-1:0] cmd_a;
        input [11:0] a;
        cmd_a = {{(AW-12){1'b0}}, a};
    endfunction

    // Sequence length per operation: unlock, entry, action, exit; array read is the action alone
    function [3:0] seq_len;
        input [3:0] o;
        case (o)
            OP_ID_READ, OP_SECID_RD, OP_PSR_RD, OP_VPB_RD, OP_NONVOLATILE_PROTECT_BIT_RD: seq_len = 4'h5;
            OP_SECID_PRG, OP_PSR_PRG, OP_VPB_SET, OP_NONVOLATILE_PROTECT_BIT_PRG, OP_NONVOLATILE_PROTECT_BIT_ERS: seq_len = 4'h6;
            OP_BYP_PROG, OP_BYP_ERASE: seq_len = 4'h7;
            default: seq_len = 4'h1;
        endcase
    endfunction

    function [DW-1:0] entry_code;
        input [3:0] o;
        case (o)
            OP_SECID_RD, OP_SECID_PRG: entry_code = `FPC_CMD_SECID;
            OP_PSR_RD, OP_PSR_PRG:     entry_code = `FPC_CMD_PSR_ENTRY;
            OP_VPB_SET, OP_VPB_RD:     entry_code = `FPC_CMD_VPB_ENTRY;
            OP_NONVOLATILE_PROTECT_BIT_PRG, OP_NONVOLATILE_PROTECT_BIT_ERS, OP_NONVOLATILE_PROTECT_BIT_RD: entry_code = `FPC_CMD_NONVOLATILE_PROTECT_BIT_ENTRY;
            OP_BYP_PROG, OP_BYP_ERASE: entry_code = `FPC_CMD_BYPASS;
            default:                   entry_code = `FPC_CMD_ID_ENTRY;
        endcase
    endfunction

    // Host-side refusals of requests the device would ignore or forbid
    wire psr_bad = ((CMD_DATA_I & `FPC_PSR_RSVD_MASK) != `FPC_PSR_RSVD_MASK)
                 | (!CMD_DATA_I[`FPC_PSR_PASSWD] & !CMD_DATA_I[`FPC_PSR_PASSTHRU]);
    wire sec_bad = (CMD_ADDR_I < `FPC_SECID_USR_LO) | (CMD_ADDR_I > `FPC_SECID_USR_HI);
    wire req_bad = ((CMD_OP_I == OP_PSR_PRG) & psr_bad) | ((CMD_OP_I == OP_SECID_PRG) & sec_bad)
                 | (CMD_OP_I > OP_ARRAY_RD);

    // Word at each step; reads return through the action step
    always @* begin
        sq_wr = 1'b1;
        sq_addr = cmd_a(`FPC_CMD_ADDR);
        sq_data = `FPC_CMD_EXIT;
        case (step)
            4'h0: begin
                sq_addr = cmd_a(`FPC_UNLOCK_ADDR1);
                sq_data = `FPC_UNLOCK_DATA1;
                if (nsteps == 4'h1) begin
                    sq_wr = 1'b0;
                    sq_addr = addr;
                end
            end
            4'h1: begin
                sq_addr = cmd_a(`FPC_UNLOCK_ADDR2);
                sq_data = `FPC_UNLOCK_DATA2;
            end
            4'h2: sq_data = entry_code(op);
            4'h3: begin
                sq_addr = addr;
                sq_data = data;
                case (op)
                    OP_SECID_PRG, OP_PSR_PRG, OP_NONVOLATILE_PROTECT_BIT_PRG, OP_BYP_PROG: sq_data = `FPC_CMD_PROG;
                    OP_NONVOLATILE_PROTECT_BIT_ERS:  sq_data = `FPC_CMD_ERASE;
                    OP_BYP_ERASE: sq_data = `FPC_CMD_ERASE;
                    OP_VPB_SET:   sq_data = `FPC_CMD_PROG;
                    default:      sq_wr = 1'b0;
                endcase
            end
            4'h4: begin
                sq_addr = addr;
                sq_data = data;
                if (op == OP_NONVOLATILE_PROTECT_BIT_ERS) sq_data = `FPC_CMD_ERASE2;
                if (op == OP_BYP_ERASE) sq_data = data;
                if (seq_len(op) == 4'h5) sq_data = `FPC_CMD_EXIT;
            end
            4'h5: begin
                sq_data = `FPC_CMD_EXIT;
                if (seq_len(op) == 4'h7) sq_data = `FPC_CMD_BYP_EXIT1;
            end
            default: begin
                sq_addr = {AW{1'b0}};
                sq_data = `FPC_CMD_BYP_EXIT2;
            end
        endcase
    end

    always @(posedge SYS_CLK_I) begin
        bc_start <= 1'b0;
        CMD_DONE_O <= 1'b0;
        if (SRST_I) begin
            state <= ST_IDLE; op <= 4'h0; addr <= {AW{1'b0}}; data <= {DW{1'b0}};
            step <= 4'h0; nsteps <= 4'h0; poll_cnt <= 16'h0000; poll_first <= 1'b0;
            poll_last <= {DW{1'b0}}; err <= 1'b0; bc_wr <= 1'b0; bc_addr <= {AW{1'b0}};
            bc_data <= {DW{1'b0}}; CMD_READY_O <= 1'b0; CMD_ERR_O <= 1'b0;
            CMD_RDATA_O <= {DW{1'b0}};
        end else begin
            case (state)
                ST_IDLE: begin
                    CMD_READY_O <= 1'b1;
                    if (CMD_VALID_I && CMD_READY_O) begin
                        CMD_READY_O <= 1'b0;
                        op <= CMD_OP_I; addr <= CMD_ADDR_I; data <= CMD_DATA_I;
                        if (req_bad) begin
                            CMD_ERR_O <= 1'b1;
                            state <= ST_DONE;
                        end else begin
                            CMD_ERR_O <= 1'b0;
                            nsteps <= seq_len(CMD_OP_I);
                            step <= 4'h0;
                            state <= ST_SEQ;
                        end
                    end
                end
                ST_SEQ: begin
                    bc_start <= 1'b1; bc_wr <= sq_wr; bc_addr <= sq_addr; bc_data <= sq_data;
                    state <= ST_WAIT;
                end
                ST_WAIT: if (bc_done) begin
                    if (!sq_wr) CMD_RDATA_O <= bc_rdata;
                    poll_first <= 1'b1; poll_cnt <= 16'h0000;
                    // Program and erase steps end by toggle polling
                    if (sq_wr && step == 4'h4 && seq_len(op) != 4'h5) state <= ST_POLL;
                    else if (step + 4'h1 == nsteps) state <= ST_DONE;
                    else begin step <= step + 4'h1; state <= ST_SEQ; end
                end
                ST_POLL: begin
                    // Toggle bit read; two equal reads end the operation
                    if (!bc_start && !bc_done && poll_cnt[0] == 1'b0) begin
                        bc_start <= 1'b1; bc_wr <= 1'b0; bc_addr <= addr; poll_cnt <= poll_cnt + 16'h0001;
                    end
                    if (bc_done) begin
                        poll_first <= 1'b0; poll_last <= bc_rdata; poll_cnt <= poll_cnt + 16'h0001;
                        if (!poll_first && bc_rdata[6] == poll_last[6]) begin
                            step <= step + 4'h1; state <= ST_SEQ;
                        // Limit counts finished reads; a long chip erase needs a larger POLL_MAX
                        end else if (poll_cnt[15:1] >= POLL_MAX[14:0]) begin
                            err <= 1'b1; step <= step + 4'h1; state <= ST_SEQ;
                        end
                    end
                end
                ST_DONE: begin
                    CMD_DONE_O <= 1'b1; CMD_ERR_O <= CMD_ERR_O | err; err <= 1'b0;
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    fpc_bus_cycle #(.AW(AW), .DW(DW)) u_cyc (
        .clk_i     (SYS_CLK_I),
        .srst_i    (SRST_I),
        .start_i   (bc_start),
        .wr_i      (bc_wr),
        .addr_i    (bc_addr),
        .data_i    (bc_data),
        .done_o    (bc_done),
        .rdata_o   (bc_rdata),
        .dq_i      (DQ_I),
        .dq_o      (DQ_O),
        .dq_oe_n_o (DQ_OE_N_O),
        .a_o       (A_O),
        .ce_n_o    (CE_N_O),
        .we_n_o    (WE_N_O),
        .oe_n_o    (OE_N_O)
    );
endmodule
`default_nettype wire

// *** rtl/fpc_consts.vh ***
`ifndef FPC_CONSTS_VH
`define FPC_CONSTS_VH
// Command codes and addresses; the unlock pair is the usual flash prefix
`define FPC_UNLOCK_ADDR1   12'h555
`define FPC_UNLOCK_DATA1   16'h00aa
`define FPC_UNLOCK_ADDR2   12'h2aa
`define FPC_UNLOCK_DATA2   16'h0055
`define FPC_CMD_ADDR       12'h555
`define FPC_CMD_ID_ENTRY   16'h0090
`define FPC_CMD_SECID      16'h0088
`define FPC_CMD_BYPASS     16'h0020
`define FPC_CMD_PSR_ENTRY  16'h00c0
`define FPC_CMD_VPB_ENTRY  16'h00e0
`define FPC_CMD_NONVOLATILE_PROTECT_BIT_ENTRY 16'h00e2
`define FPC_CMD_EXIT       16'h00f0
`define FPC_CMD_BYP_EXIT1  16'h0090
`define FPC_CMD_BYP_EXIT2  16'h0000
`define FPC_CMD_PROG       16'h00a0
`define FPC_CMD_ERASE      16'h0080
`define FPC_CMD_ERASE2     16'h0030
`define FPC_CMD_SET        16'h0000
`define FPC_CMD_CLR        16'h0001
// Identification and security space addresses
`define FPC_ADDR_MAKER     22'h000000
`define FPC_ADDR_DEVICE    22'h000001
`define FPC_ADDR_IRREV     22'h0005fe
`define FPC_SECID_USR_LO   22'h000100
`define FPC_SECID_USR_HI   22'h0001ff
`define FPC_SECID_UID_HI   22'h000007
// Settings register fields
`define FPC_PSR_VPB_RST    4
`define FPC_PSR_PASSWD     2
`define FPC_PSR_PASSTHRU   1
`define FPC_PSR_SECLOCK    0
`define FPC_PSR_RSVD_MASK  16'hffe8
`define FPC_PSR_DEFAULT    16'hffff
`define FPC_IRREV_BIT      0
// Timing in ns at 4 ns per clock
`define FPC_CLK_NS         4
`define FPC_NONVOLATILE_PROTECT_BIT_PROG_NS   20000
`define FPC_CYC_NS         100
`endif

// *** rtl/fpc_bus_cycle.v ***
`default_nettype none
`include "fpc_consts.vh"
// One asynchronous flash bus cycle, write or read, fixed length
module fpc_bus_cycle #(
    parameter AW = 22,
    parameter DW = 16
) (
    // Clock and reset
    input  wire          clk_i,
    input  wire          srst_i,
    // Request
    input  wire          start_i,
    input  wire          wr_i,
    input  wire [AW-1:0] addr_i,
    input  wire [DW-1:0] data_i,
    output reg           done_o,
    output reg  [DW-1:0] rdata_o,
    // Flash pins
    input  wire [DW-1:0] dq_i,
    output reg  [DW-1:0] dq_o,
    output reg           dq_oe_n_o,
    output reg  [AW-1:0] a_o,
    output reg           ce_n_o,
    output reg           we_n_o,
    output reg           oe_n_o
);
    localparam CYC = (`FPC_CYC_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS;
    reg [7:0] cnt;
    reg       busy;
    reg       wr;
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        if (srst_i) begin
            busy <= 1'b0; cnt <= 8'h00; wr <= 1'b0; rdata_o <= {DW{1'b0}};
            dq_o <= {DW{1'b0}}; dq_oe_n_o <= 1'b1; a_o <= {AW{1'b0}};
            ce_n_o <= 1'b1; we_n_o <= 1'b1; oe_n_o <= 1'b1;
        end else if (!busy) begin
            if (start_i) begin
                busy <= 1'b1; cnt <= 8'h00; wr <= wr_i; a_o <= addr_i; dq_o <= data_i;
                dq_oe_n_o <= ~wr_i; ce_n_o <= 1'b0; we_n_o <= ~wr_i; oe_n_o <= wr_i;
            end
        end else if (cnt == CYC[7:0] - 8'h01) begin
            // Data latched by the flash on the rising strobe
            busy <= 1'b0; done_o <= 1'b1; ce_n_o <= 1'b1; we_n_o <= 1'b1; oe_n_o <= 1'b1;
            dq_oe_n_o <= 1'b1;
            if (!wr) rdata_o <= dq_i;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule
`default_nettype wire

// *** testbench/fpc_checker.sv ***
`default_nettype none
module fpc_checker #(
    parameter AW = 22,
    parameter DW = 16,
    parameter POLL_MAX = 5000
) (
    // Clock and reset
    input wire logic       SYS_CLK_I,
    input wire logic       SRST_I,
    // User side
    input wire logic       CMD_VALID_I,
    input wire logic [3:0] CMD_OP_I,
    input wire logic       CMD_READY_O,
    input wire logic       CMD_DONE_O,
    input wire logic       CMD_ERR_O,
    // Flash strobes
    input wire logic       DQ_OE_N_O,
    input wire logic       CE_N_O,
    input wire logic       WE_N_O,
    input wire logic       OE_N_O
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] low_cnt;
    always @(posedge SYS_CLK_I) begin
        if (SRST_I || WE_N_O) low_cnt <= 8'h00;
        else low_cnt <= low_cnt + 8'h01;
    end
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (SRST_I);
    a_reset_idle: assert property (disable iff (1'b0) SRST_I |=>
        !CMD_READY_O && CE_N_O && WE_N_O && OE_N_O && DQ_OE_N_O) else $error("outputs not idle in reset");
    a_ready_up: assert property ($fell(SRST_I) |=> CMD_READY_O) else $error("ready late after reset");
    a_done_pulse: assert property (CMD_DONE_O |=> !CMD_DONE_O && CMD_READY_O) else $error("done not one pulse");
    a_take_busy: assert property (CMD_VALID_I && CMD_READY_O |=> !CMD_READY_O) else $error("ready kept on take");
    a_bad_op: assert property (CMD_VALID_I && CMD_READY_O && CMD_OP_I > 4'hc |->
        ##[1:3] (CMD_DONE_O && CMD_ERR_O)) else $error("bad op not refused");
    a_bad_nobus: assert property (CMD_VALID_I && CMD_READY_O && CMD_OP_I > 4'hc |-> CE_N_O [*4])
        else $error("bus used for bad op");
    a_strobe_ce: assert property (!(WE_N_O && OE_N_O) |-> !CE_N_O && (WE_N_O || OE_N_O))
        else $error("strobe without select");
    a_read_hiz: assert property (!OE_N_O |-> DQ_OE_N_O) else $error("driving during read");
    a_we_width: assert property ($rose(WE_N_O) |-> low_cnt == 8'h19) else $error("write strobe width");
    a_idle_bus: assert property (CMD_READY_O |-> CE_N_O) else $error("bus busy while idle");
endmodule
bind fpc_ctrl fpc_checker #(.AW(AW), .DW(DW), .POLL_MAX(POLL_MAX)) chk (.SYS_CLK_I(SYS_CLK_I),
    .SRST_I(SRST_I), .CMD_VALID_I(CMD_VALID_I), .CMD_OP_I(CMD_OP_I), .CMD_READY_O(CMD_READY_O),
    .CMD_DONE_O(CMD_DONE_O), .CMD_ERR_O(CMD_ERR_O), .DQ_OE_N_O(DQ_OE_N_O), .CE_N_O(CE_N_O),
    .WE_N_O(WE_N_O), .OE_N_O(OE_N_O));
`default_nettype wire

// *** testbench/fpc_flash_model.sv ***
`default_nettype none
module fpc_flash_model #(
    parameter logic [15:0] MAKER = 16'h00a5,
    parameter logic [15:0] DEVICE = 16'h5a5a,
    parameter logic [15:0] UID = 16'h3c3c,
    parameter int BUSY_READS = 3
) (
    // Flash pins
    input  wire logic [21:0] a_i,
    input  wire logic [15:0] dq_i,
    input  wire logic        dq_oe_n_i,
    input  wire logic        ce_n_i,
    input  wire logic        we_n_i,
    input  wire logic        oe_n_i,
    output wire logic [15:0] dq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Maker, device and unique codes are arbitrary
    int mode = 0, us = 0, pend = 0, busy = 0, cycles = 0, nrd = 0;
    bit stuck = 0, prog_seen = 0, tog = 0;
    logic [15:0] protection_settings = 16'hffff;
    logic [15:0] rd_val = 16'h0000;
    logic [127:0] volatile_protect_bit, nonvolatile_protect_bit = '1;
    bit irrev = 0, glock = 1;
    logic [15:0] sec_mem [0:255];
    // Strobes and select move in one step, so act on the combined level
    wire wr_act = !ce_n_i && !we_n_i;
    wire rd_act = !ce_n_i && !oe_n_i;
    // Released bus shows inverted data so a late sample is not hidden
    assign dq_o = rd_act ? rd_val : ~rd_val;
    initial begin
        volatile_protect_bit = {128{protection_settings[4]}};
        for (int k = 0; k < 256; k++) sec_mem[k] = 16'hffff;
    end
    always @(negedge wr_act) begin
        begin
            cycles++;
            if (dq_i == 16'h00f0) begin mode = 0; us = 0; pend = 0; busy = 0; end
            else if (pend == 1 || pend == 2) begin
                if (pend == 1 && mode == 4 && (dq_i & 16'hffe8) == 16'hffe8 && (protection_settings[2:1] & dq_i[2:1]) != 2'b00)
                    protection_settings = protection_settings & dq_i;
                // Security words only lose ones, and only while unlocked; no erase reaches them
                if (pend == 1 && mode == 2 && protection_settings[0] && a_i >= 22'h000100 && a_i <= 22'h0001ff)
                    sec_mem[a_i[7:0]] = sec_mem[a_i[7:0]] & dq_i;
                if (pend == 1 && mode == 5) volatile_protect_bit[a_i[21:15]] = dq_i[0];
                if (mode == 6 && !irrev && glock) begin
                    if (pend == 1) nonvolatile_protect_bit[a_i[21:15]] = 1'b0;
                    else nonvolatile_protect_bit = '1;
                end
                busy = BUSY_READS;
                prog_seen = 1;
                pend = 0;
            end
            else if (pend == 3) begin mode = (dq_i == 16'h0000) ? 0 : 3; pend = 0; end
            else if (us == 2) begin
                us = 0;
                case (dq_i)
                    16'h0090: mode = 1;
                    16'h0088: mode = 2;
                    16'h0020: mode = 3;
                    16'h00c0: mode = 4;
                    16'h00e0: mode = 5;
                    16'h00e2: mode = 6;
                    16'h00a0: pend = 1;
                    16'h0080: pend = 2;
                    default: mode = 0;
                endcase
            end
            else if (mode == 3 && dq_i == 16'h0090) pend = 3;
            else if (mode != 0 && (dq_i == 16'h00a0 || dq_i == 16'h0080)) pend = dq_i[5] ? 1 : 2;
            else if (a_i == 22'h000555 && dq_i == 16'h00aa) us = 1;
            else if (us == 1 && a_i == 22'h0002aa && dq_i == 16'h0055) us = 2;
            else begin us = 0; if (mode != 3) mode = 0; end
        end
    end
    always @(posedge rd_act) begin
        #1;
        begin
            cycles++;
            nrd++;
            if (busy > 0) begin tog = ~tog; rd_val = {9'h000, tog, 6'h00}; if (!stuck) busy--; end
            else if (mode == 1)
                rd_val = (a_i == 0) ? MAKER : (a_i == 1) ? DEVICE : (a_i == 22'h0005fe) ? {15'h7fff, !irrev}
                       : {15'h0000, !(volatile_protect_bit[a_i[21:15]] && nonvolatile_protect_bit[a_i[21:15]])};
            else if (mode == 2)
                rd_val = (a_i <= 7) ? UID ^ a_i[15:0]
                       : (a_i >= 22'h000100 && a_i <= 22'h0001ff) ? sec_mem[a_i[7:0]] : 16'hffff;
            else if (mode == 4) rd_val = protection_settings;
            else if (mode == 5) rd_val = {15'h0000, volatile_protect_bit[a_i[21:15]]};
            else if (mode == 6) rd_val = {15'h0000, nonvolatile_protect_bit[a_i[21:15]]};
            else rd_val = ~a_i[15:0];
        end
    end
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, srst = 1, valid = 0;
    logic [3:0]  op = 0;
    logic [21:0] addr = 0, a;
    logic [15:0] data = 0, rdata, dq_in, dq_out;
    logic        ready, done, err, dq_oe_n, ce_n, we_n, oe_n;
    logic [7:0]  seed = 8'h50;
    int          failures = 0, compares = 0;
    bit          exp_q[$];
    initial forever #2 clk = ~clk;
    fpc_ctrl #(.POLL_MAX(20)) dut (.SYS_CLK_I(clk), .SRST_I(srst), .CMD_VALID_I(valid), .CMD_OP_I(op),
        .CMD_ADDR_I(addr), .CMD_DATA_I(data), .CMD_READY_O(ready), .CMD_DONE_O(done), .CMD_ERR_O(err),
        .CMD_RDATA_O(rdata), .DQ_I(dq_in), .DQ_O(dq_out), .DQ_OE_N_O(dq_oe_n), .A_O(a), .CE_N_O(ce_n),
        .WE_N_O(we_n), .OE_N_O(oe_n));
    fpc_flash_model m (.a_i(a), .dq_i(dq_out), .dq_oe_n_i(dq_oe_n), .ce_n_i(ce_n), .we_n_i(we_n),
        .oe_n_i(oe_n), .dq_o(dq_in));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic run_op(input logic [3:0] o, input logic [21:0] ad, input logic [15:0] da);
        int n, c0, r0;
        c0 = m.cycles;
        r0 = m.nrd;
        m.prog_seen = 0;
        @(negedge clk);
        valid = 1;
        op = o;
        addr = ad;
        data = da;
        n = 0;
        while (ready !== 1'b1 && n < 100) begin @(negedge clk); n++; end
        @(negedge clk);
        valid = 0;
        while (done !== 1'b1 && n < 4000) begin @(posedge clk); #1; n++; end
        if (n >= 4000) begin
            failures++;
            give_verdict();
        end
        // No bus traffic means a refusal; a stuck poll means a timeout
        exp_q.push_back(m.cycles == c0 || (m.stuck && m.prog_seen));
        check("err", err, exp_q.pop_front());
        if (o > 4'hc) check("bus cycles", m.cycles, c0);
        // Read data only follows the read step; poll reads do not reach it
        if (m.nrd != r0 && o inside {4'h0, 4'h1, 4'h3, 4'h6, 4'h9, 4'hc}) check("rdata", rdata, m.rd_val);
        check("device mode", m.mode, 0);
    endtask
    initial begin
        repeat (4) @(negedge clk);
        srst = 0;
        for (int i = 0; i < 16; i++) run_op(i[3:0], 22'h000000, 16'hffff);
        $display("test all ops at address zero done");
        run_op(4'h0, 22'h000001, 16'h0000);
        check("device code", rdata, m.DEVICE);
        run_op(4'h0, 22'h0005fe, 16'h0000);
        check("irreversible", rdata[0], 1'b1);
        run_op(4'h7, 22'h008000, 16'h0000);
        run_op(4'h0, 22'h008000, 16'h0000);
        check("block status", rdata, 16'h0001);
        $display("test identification reads done");
        for (int i = 0; i < 13; i++) begin
            seed = lfsr(seed);
            run_op(i[3:0], 22'h000100 + {14'h0000, seed}, 16'hffef);
        end
        check("settings", m.protection_settings, 16'hffef);
        $display("test security range and settings program done");
        srst = 1;
        repeat (4) @(negedge clk);
        srst = 0;
        m.stuck = 1;
        for (int i = 0; i < 13; i++) run_op(i[3:0], 22'h000100 + {14'h0000, seed}, 16'hffff);
        $display("test poll timeout after reset done");
        give_verdict();
    end
endmodule
`default_nettype wire
